// ===== shared/gmp_pkg.sv
// shared constants and carriers for the instrument message port
package gmp_pkg;

  // ----------------------------------------------------------------
  // bus command codes (7-bit, compared with the parity bit dropped)
  // ----------------------------------------------------------------
  localparam logic [7:0] LISTEN_OFS = 8'h20;
  localparam logic [7:0] TALK_OFS   = 8'h40;
  localparam logic [7:0] UC_CLEAR   = 8'h14;
  localparam logic [7:0] UC_UNLSN   = 8'h3F;
  localparam logic [7:0] UC_UNTLK   = 8'h5F;
  localparam logic [7:0] AC_LOCAL   = 8'h01;
  localparam logic [7:0] AC_SCLEAR  = 8'h04;
  localparam logic [7:0] UC_SPOLL_EN  = 8'h18;
  localparam logic [7:0] UC_SPOLL_DIS = 8'h19;
  localparam logic [4:0] ADDR_NONE  = 5'h1F;

  // ----------------------------------------------------------------
  // characters and fixed bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_LF    = 8'h0A;
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_SP    = 8'h20;
  localparam logic [7:0] CH_SEMI  = 8'h3B;
  localparam logic [7:0] CH_QM    = 8'h3F;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CASE_MSK = 8'hDF;
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  localparam logic [7:0] STB_RQS  = 8'h40;
  localparam logic [31:0] KW_INIT  = 32'h494E_4954;
  localparam logic [39:0] KW_EVENT = 40'h45_5645_4E54;
  localparam int HDR_MAX   = 6;
  localparam int OUT_DEPTH = 512;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {OS_IDLE, OS_CR, OS_LF, OS_DONE} gmp_os_e;

  typedef struct packed {
    logic       valid;
    logic       atn;
    logic       eoi;
    logic [7:0] data;
  } gmp_rx_s;

  typedef struct packed {
    logic       valid;
    logic       eoi;
    logic [7:0] data;
  } gmp_tx_s;

  typedef struct packed {
    logic        valid;
    logic        pair;
    logic [7:0]  data;
    logic [15:0] x;
    logic [15:0] y;
  } gmp_resp_s;

  typedef struct packed {
    logic        valid;
    logic        query;
    logic [47:0] header;
  } gmp_exec_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } gmp_err_s;

endpackage

// ===== design/gmp_sync.sv
// two-stage synchroniser for pin levels
`timescale 1ns/1ps
module gmp_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  import gmp_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } gmp_sync_s;

  gmp_sync_s r_reg;
  gmp_sync_s r_next;

  if (W < 1) begin : g_chk
    $error("gmp_sync: width must be at least one");
  end

  always_comb begin
    r_next.s1 = i_d;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_q = r_reg.s2;
endmodule

// ===== design/gmp_port.sv
// device-side message port: addressing, parsing, buffered replies
// Contract
// - talked with empty output buffer: send all-ones byte with EOI
// - queries always answered; setting commands refused unless remote
// - listen address is primary address plus 32
// - device clear empties input and output buffers, execution continues
// - pending reply aborted by device clear or new device input
// - universal codes: 20 clear, 63 unlisten, 95 untalk
// - addressed codes need own listen: 1 go-to-local, 4 selected clear
// - IFC: unlisten, untalk, serial poll disabled
// - init command returns all controls to power-up state
// - mnemonic followed by question mark is a query, reply buffered
// - event query returns the code of the last error
// - settings dump: one unit per function, about 500 characters
// - curve pair sent as x high, x low, y high, y low
// - terminator switch: LF or EOI, or EOI only; output matches
// - primary address 31 answers no address
// - units executed only at terminator or semicolon, in order
`timescale 1ns/1ps
module gmp_port #(
  parameter int DEPTH = gmp_pkg::OUT_DEPTH
) (
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  input  wire gmp_pkg::gmp_rx_s   i_rx,
  input  wire logic              i_tx_ready,
  input  wire gmp_pkg::gmp_resp_s i_resp,
  input  wire gmp_pkg::gmp_err_s  i_err,
  input  wire logic              i_ifc,
  input  wire logic              i_ren,
  input  wire logic [4:0]        i_addr_sw,
  input  wire logic              i_term_eoi_sw,
  input  wire logic              i_reread,
  output gmp_pkg::gmp_tx_s        o_tx,
  output logic                   o_resp_ready,
  output gmp_pkg::gmp_exec_s      o_exec,
  output logic                   o_init,
  output logic                   o_srq,
  output logic                   o_listen,
  output logic                   o_talk,
  output logic                   o_remote
);
  import gmp_pkg::*;

  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        listen;
    logic        talk;
    logic        spoll;
    logic        remote;
    logic        cfg;
    logic [1:0]  warm;
    logic        term_eoi;
    logic        msg_open;
    logic        hdone;
    logic        qmark;
    logic        rqs;
    logic [4:0]  addr;
    logic [47:0] hdr;
    logic [2:0]  hlen;
    logic [7:0]  evt;
    logic [31:0] stg;
    logic [2:0]  stg_cnt;
    gmp_os_e     os;
    gmp_tx_s     tx;
    gmp_exec_s   ex;
    logic        init;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } gmp_st_s;

  gmp_st_s    r_reg;
  gmp_st_s    r_next;
  logic [7:0] mem [DEPTH];
  logic [8:0] sync_q;
  logic       ifc_s;
  logic       ren_s;
  logic       term_s;
  logic       reread_s;
  logic [4:0] addr_s;
  logic       wr;
  logic       wr_eff;
  logic [7:0] wd;
  logic       clr_out;
  logic       rdy;
  logic [7:0] c7;
  logic [7:0] mla;
  logic       mine;
  logic       mla_hit;

  if (DEPTH < 512 || (1 << AW) != DEPTH) begin : g_chk
    $error("gmp_port: depth must be a power of two, at least 512");
  end

  // pins cross into the clock domain before any decode
  gmp_sync #(.W(9)) u_sync (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_d    ({i_ifc, i_ren, i_term_eoi_sw, i_reread, i_addr_sw}),
    .o_q    (sync_q)
  );
  assign {ifc_s, ren_s, term_s, reread_s, addr_s} = sync_q;

  assign c7      = {1'b0, i_rx.data[6:0]};
  assign mla     = LISTEN_OFS + {3'b000, r_reg.addr};
  assign mine    = r_reg.cfg && r_reg.addr != ADDR_NONE;
  assign mla_hit = i_rx.valid && i_rx.atn && mine && c7 == mla;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic       term;
    logic       dd;
    logic       evt_load;
    logic       nq;
    logic       nd;
    logic [2:0] nl;
    logic [47:0] nh;
    logic [7:0] up;
    term     = 1'b0;
    dd       = i_rx.valid && !i_rx.atn && r_reg.listen;
    evt_load = 1'b0;
    nq       = r_reg.qmark;
    nd       = r_reg.hdone;
    nl       = r_reg.hlen;
    nh       = r_reg.hdr;
    up       = i_rx.data;
    if (i_rx.data >= 8'h61 && i_rx.data <= 8'h7A) begin
      up = i_rx.data & CASE_MSK;
    end
    r_next   = r_reg;
    r_next.ex.valid = 1'b0;
    r_next.init     = 1'b0;
    wr       = 1'b0;
    wd       = 8'h00;
    clr_out  = 1'b0;

    // switches caught once after reset and on each reread request
    // synchroniser resets to zero, so wait until it carries the pins
    r_next.warm = {r_reg.warm[0], 1'b1};
    if ((r_reg.warm[1] && !r_reg.cfg) || reread_s) begin
      r_next.cfg      = 1'b1;
      r_next.addr     = addr_s;
      r_next.term_eoi = term_s;
    end

    // interface messages, sent with ATN
    if (i_rx.valid && i_rx.atn) begin
      if (mla_hit) begin
        r_next.listen = 1'b1;
        r_next.talk   = 1'b0;
        if (ren_s) begin
          r_next.remote = 1'b1;
        end
      end else if (mine && c7 == TALK_OFS + {3'b000, r_reg.addr}) begin
        r_next.talk   = 1'b1;
        r_next.listen = 1'b0;
      end else if (c7 == UC_UNLSN) begin
        r_next.listen = 1'b0;
      end else if (c7 == UC_UNTLK) begin
        r_next.talk = 1'b0;
      end else if (c7 == UC_CLEAR ||
                   (c7 == AC_SCLEAR && r_reg.listen)) begin
        clr_out = 1'b1;
      end else if (c7 == AC_LOCAL && r_reg.listen) begin
        r_next.remote = 1'b0;
      end else if (c7 == UC_SPOLL_EN) begin
        r_next.spoll = 1'b1;
      end else if (c7 == UC_SPOLL_DIS) begin
        r_next.spoll = 1'b0;
      end
    end
    if (!ren_s) begin
      r_next.remote = 1'b0;
    end
    // checked after the commands, so a same-cycle address cannot win
    if (r_next.addr == ADDR_NONE) begin
      r_next.listen = 1'b0;
      r_next.talk   = 1'b0;
    end

    // device-dependent bytes; header kept, arguments go unparsed
    if (dd) begin
      if (!r_reg.msg_open) begin
        r_next.msg_open = 1'b1;
        clr_out = 1'b1;
      end
      term = i_rx.eoi || (!r_reg.term_eoi && i_rx.data == CH_LF);
      if (i_rx.data == CH_QM) begin
        nq = 1'b1;
      end else if (i_rx.data == CH_SP || i_rx.data == CH_CR ||
                   i_rx.data == CH_LF) begin
        nd = nl != 3'd0;
      end else if (i_rx.data != CH_SEMI && !nd &&
                   nl < 3'(HDR_MAX)) begin
        nh = {r_reg.hdr[39:0], up};
        nl = r_reg.hlen + 3'd1;
      end
      r_next.hdr   = nh;
      r_next.hlen  = nl;
      r_next.qmark = nq;
      r_next.hdone = nd;
      if (i_rx.data == CH_SEMI || term) begin
        if (nl != 3'd0) begin
          if (nq) begin
            if (nl == 3'd5 && nh[39:0] == KW_EVENT) begin
              // event code as three decimal digits
              evt_load       = 1'b1;
              r_next.stg     = {CH_ZERO + r_reg.evt / 8'd100,
                                CH_ZERO + (r_reg.evt / 8'd10) % 8'd10,
                                CH_ZERO + r_reg.evt % 8'd10, 8'h00};
              r_next.stg_cnt = 3'd3;
              r_next.evt     = 8'h00;
            end else begin
              r_next.ex = '{valid: 1'b1, query: 1'b1, header: nh};
            end
          end else if (r_reg.remote) begin
            if (nl == 3'd4 && nh[31:0] == KW_INIT) begin
              r_next.init = 1'b1;
            end else begin
              r_next.ex = '{valid: 1'b1, query: 1'b0, header: nh};
            end
          end
        end
        r_next.hdr   = '0;
        r_next.hlen  = 3'd0;
        r_next.qmark = 1'b0;
        r_next.hdone = 1'b0;
        if (term) begin
          r_next.msg_open = 1'b0;
        end
      end
    end

    // reply bytes into the output buffer; curve pairs split high first
    rdy = r_reg.stg_cnt == 3'd0 && !evt_load;
    if (r_reg.stg_cnt != 3'd0) begin
      wr = 1'b1;
      wd = r_reg.stg[31:24];
      r_next.stg     = {r_reg.stg[23:0], 8'h00};
      r_next.stg_cnt = r_reg.stg_cnt - 3'd1;
    end else if (i_resp.valid && rdy) begin
      if (i_resp.pair) begin
        r_next.stg     = {i_resp.x, i_resp.y};
        r_next.stg_cnt = 3'd4;
      end else begin
        wr = 1'b1;
        wd = i_resp.data;
      end
    end

    // talker; overflow bytes are simply lost
    if (r_reg.tx.valid && i_tx_ready) begin
      r_next.tx.valid = 1'b0;
    end
    if (!r_reg.talk) begin
      r_next.os = OS_IDLE;
    end else if (!i_rx.atn && (!r_reg.tx.valid || i_tx_ready)) begin
      if (r_reg.spoll) begin
        r_next.tx  = '{valid: 1'b1, eoi: 1'b0,
                       data: r_reg.rqs ? STB_RQS : 8'h00};
        r_next.rqs = 1'b0;
      end else begin
        case (r_reg.os)
          OS_IDLE: begin
            if (r_reg.cnt != '0) begin
              r_next.tx = '{valid: 1'b1, data: mem[r_reg.rp],
                            eoi: r_reg.cnt == 1 && r_reg.term_eoi};
              r_next.rp  = r_reg.rp + 1'b1;
              r_next.cnt = r_reg.cnt - 1'b1;
              if (r_reg.cnt == 1) begin
                r_next.os = r_reg.term_eoi ? OS_DONE : OS_CR;
              end
            end else begin
              r_next.tx = '{valid: 1'b1, eoi: 1'b1, data: FILL_BYTE};
              r_next.os = OS_DONE;
            end
          end
          OS_CR: begin
            r_next.tx = '{valid: 1'b1, eoi: 1'b0, data: CH_CR};
            r_next.os = OS_LF;
          end
          OS_LF: begin
            r_next.tx = '{valid: 1'b1, eoi: 1'b1, data: CH_LF};
            r_next.os = OS_DONE;
          end
          default: begin
            r_next.os = OS_DONE;
          end
        endcase
      end
    end

    wr_eff = wr && !clr_out && r_next.cnt < (AW+1)'(DEPTH);
    if (wr_eff) begin
      r_next.wp  = r_reg.wp + 1'b1;
      r_next.cnt = r_next.cnt + 1'b1;
    end

    // clears do not touch a unit already handed to the executor
    if (clr_out) begin
      r_next.wp  = '0;
      r_next.rp  = '0;
      r_next.cnt = '0;
      r_next.stg_cnt = 3'd0;
      if (!dd) begin
        r_next.hdr      = '0;
        r_next.hlen     = 3'd0;
        r_next.qmark    = 1'b0;
        r_next.hdone    = 1'b0;
        r_next.msg_open = 1'b0;
        r_next.rqs      = 1'b0;
        r_next.evt      = 8'h00;
      end
    end
    if (ifc_s) begin
      r_next.listen = 1'b0;
      r_next.talk   = 1'b0;
      r_next.spoll  = 1'b0;
    end
    // a new error wins over any clear in the same cycle
    if (i_err.valid) begin
      r_next.evt = i_err.code;
      r_next.rqs = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // reply storage has no reset; pointers define its content
  always_ff @(posedge i_clk) begin
    if (wr_eff) begin
      mem[r_reg.wp] <= wd;
    end
  end

  assign o_tx         = r_reg.tx;
  assign o_resp_ready = rdy;
  assign o_exec       = r_reg.ex;
  assign o_init       = r_reg.init;
  assign o_srq        = r_reg.rqs;
  assign o_listen     = r_reg.listen;
  assign o_talk       = r_reg.talk;
  assign o_remote     = r_reg.remote;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  property p_fill;
    r_reg.talk && !r_reg.spoll && r_reg.os == OS_IDLE && r_reg.cnt == 0
      && !i_rx.atn && !r_reg.tx.valid
      |=> o_tx.valid && o_tx.eoi && o_tx.data == FILL_BYTE;
  endproperty
  a_fill: assert property (p_fill) else $error("no filler byte");

  property p_local;
    o_exec.valid && !o_exec.query |-> $past(r_reg.remote);
  endproperty
  a_local: assert property (p_local) else $error("setting in local");

  property p_mla;
    $rose(r_reg.listen) |-> $past(mla_hit);
  endproperty
  a_mla: assert property (p_mla) else $error("listen without address");

  property p_dcl;
    i_rx.valid && i_rx.atn && c7 == UC_CLEAR
      |=> r_reg.cnt == 0 && r_reg.stg_cnt == 0;
  endproperty
  a_dcl: assert property (p_dcl) else $error("clear left data");

  property p_abort;
    i_rx.valid && !i_rx.atn && r_reg.listen && !r_reg.msg_open
      |=> r_reg.cnt == 0 && r_reg.stg_cnt == 0;
  endproperty
  a_abort: assert property (p_abort) else $error("reply not aborted");

  property p_gtl;
    i_rx.valid && i_rx.atn && c7 == AC_LOCAL && r_reg.listen
      |=> !r_reg.remote;
  endproperty
  a_gtl: assert property (p_gtl) else $error("still remote");

  property p_ifc;
    ifc_s |=> !o_listen && !o_talk && !r_reg.spoll;
  endproperty
  a_ifc: assert property (p_ifc) else $error("ifc ignored");

  property p_none;
    r_reg.cfg && r_reg.addr == ADDR_NONE |-> !o_listen && !o_talk;
  endproperty
  a_none: assert property (p_none) else $error("address 31 answered");

  property p_pair;
    i_resp.valid && i_resp.pair && rdy && !clr_out
      |=> wd == $past(i_resp.x[15:8]) ##1 wd == $past(i_resp.x[7:0], 2)
      ##1 wd == $past(i_resp.y[15:8], 3) ##1 wd == $past(i_resp.y[7:0], 4);
  endproperty
  a_pair: assert property (p_pair) else $error("curve byte order");

  property p_term;
    r_reg.talk && !r_reg.spoll && r_reg.os == OS_IDLE && r_reg.cnt == 1
      && !i_rx.atn && !r_reg.tx.valid
      |=> o_tx.eoi == r_reg.term_eoi
      ##1 (r_reg.term_eoi || r_reg.os == OS_CR || r_reg.os == OS_LF);
  endproperty
  a_term: assert property (p_term) else $error("bad output end");

  c_fill:  cover property (o_tx.valid && o_tx.data == FILL_BYTE);
  c_query: cover property (o_exec.valid && o_exec.query);
  c_init:  cover property (o_init);
  c_lf:    cover property (o_tx.valid && o_tx.eoi && o_tx.data == CH_LF);
endmodule

// ===== tb/gmp_ctrl_model.sv
// bus controller model: sends bus bytes, accepts talker bytes
`timescale 1ns/1ps
module gmp_ctrl_model (
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire gmp_pkg::gmp_tx_s i_tx,
  input  wire logic             i_slow,
  output gmp_pkg::gmp_rx_s      o_rx,
  output logic                  o_tx_ready
);
  import gmp_pkg::*;
  logic [8:0] rx_q[$];
  logic [1:0] ph_reg;

  initial o_rx = '0;

  // ----------------------------------------------------------------
  // acceptor side: stalls every other pair of cycles when slow
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ph_reg     <= '0;
      o_tx_ready <= 1'b0;
    end else begin
      ph_reg     <= ph_reg + 2'd1;
      o_tx_ready <= i_slow ? ph_reg[1] : 1'b1;
      // binary reads end on eoi only, so bytes are kept whole
      if (i_tx.valid && o_tx_ready)
        rx_q.push_back({i_tx.eoi, i_tx.data});
    end
  end

  // ----------------------------------------------------------------
  // source side: one-cycle byte, atn dropped, data lines scrambled
  // ----------------------------------------------------------------
  task automatic send(input logic atn, input logic eoi,
                      input logic [7:0] d);
    @(posedge i_clk);
    o_rx <= '{valid: 1'b1, atn: atn, eoi: eoi, data: d};
    @(posedge i_clk);
    o_rx <= '{valid: 1'b0, atn: 1'b0, eoi: 1'b0, data: ~d};
  endtask

  // listen address carries the offset of 32
  task automatic listen(input logic [4:0] a);
    send(1'b1, 1'b0, LISTEN_OFS + {3'd0, a});
  endtask

  task automatic send_str(input string s);
    for (int i = 0; i < s.len(); i++) begin
      send(1'b0, i == s.len() - 1, s[i]);
    end
  endtask
endmodule

// ===== tb/gmp_port_bench.sv
// self-checking bench for the instrument message port
`timescale 1ns/1ps
module gmp_port_bench;
  import gmp_pkg::*;
  typedef struct packed {
    logic [7:0] code;
    logic       l;
    logic       t;
    logic       r;
  } gmp_row_s;

  logic       i_clk = 0, i_rstn = 0, i_tx_ready, i_ifc = 0, i_ren = 1;
  logic       i_term_eoi_sw = 1, i_reread = 0, slow = 0;
  logic [4:0] i_addr_sw = 5'h05;
  gmp_rx_s    i_rx;
  gmp_resp_s  i_resp = '0;
  gmp_err_s   i_err  = '0;
  gmp_tx_s    o_tx;
  gmp_exec_s  o_exec;
  logic       o_resp_ready, o_init, o_srq, o_listen, o_talk, o_remote;
  int         fail_count = 0, cmp_count = 0, cyc = 0, init_n = 0;
  logic [47:0] ex_hdr;
  logic        ex_q;
  gmp_row_s    rows[10] = '{
    '{8'h25, 1'b1, 1'b0, 1'b1}, '{8'h45, 1'b0, 1'b1, 1'b1},
    '{8'h5F, 1'b0, 1'b0, 1'b1}, '{8'h01, 1'b0, 1'b0, 1'b1},
    '{8'h25, 1'b1, 1'b0, 1'b1}, '{8'h01, 1'b1, 1'b0, 1'b0},
    '{8'h3F, 1'b0, 1'b0, 1'b0}, '{8'h26, 1'b0, 1'b0, 1'b0},
    '{8'h45, 1'b0, 1'b1, 1'b0}, '{8'h5F, 1'b0, 1'b0, 1'b0}};

  always #4 i_clk = ~i_clk;

  gmp_port gmp_port_inst (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_rx(i_rx), .i_tx_ready(i_tx_ready),
    .i_resp(i_resp), .i_err(i_err), .i_ifc(i_ifc), .i_ren(i_ren),
    .i_addr_sw(i_addr_sw), .i_term_eoi_sw(i_term_eoi_sw),
    .i_reread(i_reread), .o_tx(o_tx), .o_resp_ready(o_resp_ready),
    .o_exec(o_exec), .o_init(o_init), .o_srq(o_srq), .o_listen(o_listen),
    .o_talk(o_talk), .o_remote(o_remote));

  gmp_ctrl_model gmp_ctrl_model_inst (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_tx(o_tx), .i_slow(slow),
    .o_rx(i_rx), .o_tx_ready(i_tx_ready));

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (o_exec.valid === 1'b1) begin
      ex_hdr <= o_exec.header;
      ex_q   <= o_exec.query;
    end
    if (o_init === 1'b1) init_n <= init_n + 1;
    // hang guard sized well above the full sequence
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      end_of_test();
    end
  end

  task automatic check(input string n, input logic [31:0] seen, exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("counts: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // talk, collect n bytes under a bound, then untalk
  task automatic talk_read(input int n);
    gmp_ctrl_model_inst.rx_q.delete();
    gmp_ctrl_model_inst.send(1'b1, 1'b0, TALK_OFS + 8'h05);
    for (int i = 0; i < 300 && gmp_ctrl_model_inst.rx_q.size() < n; i++)
      @(posedge i_clk);
    repeat (8) @(posedge i_clk);
    check("byte count", gmp_ctrl_model_inst.rx_q.size(), n);
    gmp_ctrl_model_inst.send(1'b1, 1'b0, UC_UNTLK);
  endtask

  function automatic logic [31:0] got(input int i);
    return (i < gmp_ctrl_model_inst.rx_q.size()) ?
           {23'd0, gmp_ctrl_model_inst.rx_q[i]} : 32'hDEAD_BEEF;
  endfunction

  task automatic put_resp(input logic pair, input logic [7:0] d,
                          input logic [15:0] x, y);
    @(posedge i_clk);
    i_resp <= '{valid: 1'b1, pair: pair, data: d, x: x, y: y};
    @(posedge i_clk);
    i_resp.valid <= 1'b0;
    repeat (6) @(posedge i_clk);
  endtask

  initial begin
    repeat (16) @(posedge i_clk);
    check("reset", {26'd0, o_listen, o_talk, o_remote, o_srq,
                    o_tx.valid, o_init}, 32'h0000_0000);
    i_rstn <= 1'b1;
    repeat (6) @(posedge i_clk);
    // -------------------------------------------------------------
    // empty output buffer answers all ones with eoi
    // -------------------------------------------------------------
    talk_read(1);
    check("filler", got(0), 32'h0000_01FF);
    $display("test filler done");
    // -------------------------------------------------------------
    // addressing table
    // -------------------------------------------------------------
    foreach (rows[i]) begin
      gmp_ctrl_model_inst.send(1'b1, 1'b0, rows[i].code);
      repeat (2) @(posedge i_clk);
      check("listen", o_listen, rows[i].l);
      check("talk", o_talk, rows[i].t);
      check("remote", o_remote, rows[i].r);
    end
    $display("test addressing done");
    // -------------------------------------------------------------
    // setting command refused in local, taken in remote
    // -------------------------------------------------------------
    i_ren <= 1'b0;
    repeat (4) @(posedge i_clk);
    gmp_ctrl_model_inst.listen(5'h05);
    gmp_ctrl_model_inst.send_str("INIT");
    repeat (4) @(posedge i_clk);
    check("init local", init_n, 0);
    i_ren <= 1'b1;
    repeat (4) @(posedge i_clk);
    gmp_ctrl_model_inst.listen(5'h05);
    gmp_ctrl_model_inst.send_str("INIT");
    repeat (4) @(posedge i_clk);
    check("init remote", init_n, 1);
    $display("test remote done");
    // -------------------------------------------------------------
    // query, byte and curve pair reply, read with a stalling partner
    // -------------------------------------------------------------
    gmp_ctrl_model_inst.send_str("vert?");
    repeat (3) @(posedge i_clk);
    check("query", ex_q, 1'b1);
    check("header", ex_hdr[31:0], 32'h5645_5254);
    put_resp(1'b0, 8'h41, 16'h0000, 16'h0000);
    put_resp(1'b1, 8'h00, 16'h1234, 16'hABCD);
    repeat (20) @(posedge i_clk);
    slow <= 1'b1;
    talk_read(5);
    check("b0", got(0), 32'h0000_0041);
    check("x hi", got(1), 32'h0000_0012);
    check("x lo", got(2), 32'h0000_0034);
    check("y hi", got(3), 32'h0000_00AB);
    check("y lo", got(4), 32'h0000_01CD);
    slow <= 1'b0;
    $display("test query done");
    // -------------------------------------------------------------
    // error event, event query, then clear
    // -------------------------------------------------------------
    @(posedge i_clk);
    i_err <= '{valid: 1'b1, code: 8'h2A};
    @(posedge i_clk);
    i_err.valid <= 1'b0;
    repeat (2) @(posedge i_clk);
    check("srq", o_srq, 1'b1);
    gmp_ctrl_model_inst.listen(5'h05);
    gmp_ctrl_model_inst.send_str("EVENT?");
    repeat (8) @(posedge i_clk);
    talk_read(3);
    check("ev0", got(0), 32'h0000_0030);
    check("ev1", got(1), 32'h0000_0034);
    check("ev2", got(2), 32'h0000_0132);
    put_resp(1'b0, 8'h42, 16'h0000, 16'h0000);
    gmp_ctrl_model_inst.send(1'b1, 1'b0, UC_CLEAR);
    repeat (2) @(posedge i_clk);
    check("srq clr", o_srq, 1'b0);
    talk_read(1);
    check("cleared", got(0), 32'h0000_01FF);
    $display("test clear done");
    // -------------------------------------------------------------
    // lf terminator mode: new input drops a pending reply, cr lf out
    // -------------------------------------------------------------
    i_term_eoi_sw <= 1'b0;
    i_reread      <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_reread <= 1'b0;
    put_resp(1'b0, 8'h41, 16'h0000, 16'h0000);
    gmp_ctrl_model_inst.listen(5'h05);
    gmp_ctrl_model_inst.send(1'b0, 1'b0, 8'h41);
    gmp_ctrl_model_inst.send(1'b0, 1'b0, CH_LF);
    repeat (3) @(posedge i_clk);
    check("lf query", ex_q, 1'b0);
    check("lf header", ex_hdr[31:0], 32'h0000_0041);
    put_resp(1'b0, 8'h43, 16'h0000, 16'h0000);
    talk_read(3);
    check("new input", got(0), 32'h0000_0043);
    check("out cr", got(1), 32'h0000_000D);
    check("out lf", got(2), 32'h0000_010A);
    $display("test lf done");
    // -------------------------------------------------------------
    // interface clear drops addressing
    // -------------------------------------------------------------
    gmp_ctrl_model_inst.listen(5'h05);
    repeat (2) @(posedge i_clk);
    i_ifc <= 1'b1;
    repeat (6) @(posedge i_clk);
    i_ifc <= 1'b0;
    check("ifc listen", o_listen, 1'b0);
    check("ifc talk", o_talk, 1'b0);
    // -------------------------------------------------------------
    // address 31 takes a listening port off the bus
    // -------------------------------------------------------------
    repeat (3) @(posedge i_clk);
    gmp_ctrl_model_inst.listen(5'h05);
    repeat (2) @(posedge i_clk);
    check("relisten", o_listen, 1'b1);
    i_addr_sw <= 5'h1F;
    i_reread  <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_reread <= 1'b0;
    check("addr 31", o_listen, 1'b0);
    $display("test ifc done");
    end_of_test();
  end
endmodule
